// ==== include/dfh_regs.vh ====
// Function codes, indication bit positions, register offsets and reset values
`ifndef DFH_REGS_VH
`define DFH_REGS_VH
// Request function codes
`define DFH_FC_CONFIRM      8'h00
`define DFH_FC_READ         8'h01
`define DFH_FC_WRITE        8'h02
`define DFH_FC_SELECT       8'h03
`define DFH_FC_OPERATE      8'h04
`define DFH_FC_DIR_OP       8'h05
`define DFH_FC_DIR_OP_NR    8'h06
`define DFH_FC_FRZ          8'h07
`define DFH_FC_FRZ_NR       8'h08
`define DFH_FC_FRZ_CLR      8'h09
`define DFH_FC_FRZ_CLR_NR   8'h0a
`define DFH_FC_COLD         8'h0d
`define DFH_FC_WARM         8'h0e
`define DFH_FC_INIT_APP     8'h10
`define DFH_FC_START_APP    8'h11
`define DFH_FC_STOP_APP     8'h12
`define DFH_FC_UNSOL_EN     8'h14
`define DFH_FC_UNSOL_DIS    8'h15
`define DFH_FC_DELAY        8'h17
`define DFH_FC_REC_TIME     8'h18
`define DFH_FC_OPEN         8'h19
`define DFH_FC_CLOSE        8'h1a
`define DFH_FC_DELETE       8'h1b
`define DFH_FC_FINFO        8'h1c
`define DFH_FC_FAUTH        8'h1d
`define DFH_FC_ABORT        8'h1e
`define DFH_FC_ACT_CFG      8'h1f
`define DFH_FC_AUTH         8'h20
`define DFH_FC_AUTH_NR      8'h21
// Response function codes
`define DFH_FC_RESP         8'h81
`define DFH_FC_UNSOL_RESP   8'h82
`define DFH_FC_AUTH_RESP    8'h83
// Indication bit positions within the 16-bit word (first octet low)
`define DFH_IIN_ALL_ST      0
`define DFH_IIN_CLS1        1
`define DFH_IIN_CLS3        3
`define DFH_IIN_NEED_TIME   4
`define DFH_IIN_LOCAL       5
`define DFH_IIN_TROUBLE     6
`define DFH_IIN_RESTART     7
`define DFH_IIN_NO_FC       8
`define DFH_IIN_OBJ_UNK     9
`define DFH_IIN_PARAM       10
`define DFH_IIN_EVT_OVF     11
`define DFH_IIN_CFG_BAD     13
// Register word indices (as seen on avs_address, not times four)
`define DFH_A_CTRL          4'h0
`define DFH_A_STATUS        4'h1
`define DFH_A_IIN           4'h2
`define DFH_A_LAST_IIN      4'h3
`define DFH_A_SEL_PTS       4'h4
`define DFH_A_COUNT         4'h5
// Control register fields
`define DFH_CTRL_CLR_ERR    0
`define DFH_CTRL_SET_TIME   1
`define DFH_CTRL_UNSOL_REQ  2
`define DFH_CTRL_RESTART    3
// Reset values
`define DFH_RST_W16         16'h0000
`define DFH_RST_W32         32'h00000000
`define DFH_RST_B8          8'h00
`endif

// ==== rtl/dfh_outstation.v ====
// Outstation function code interpreter and internal indication keeper
`timescale 1ns/1ps
`include "dfh_regs.vh"
// Function
// - Confirm sent when request asks confirmation
// - Read request returns object data
// - Write stores objects, clears restart bit
// - Select then operate controls outputs
// - Direct operate, optionally without response
// - Freeze copies counters, optionally silent
// - Freeze-clear copies then zeroes counters
// - Cold restart full, warm restart partial
// - Initialise, start, stop user program
// - Enable or disable unsolicited messages
// - Delay measure and record current time
// - Open, close and delete files
// - File info, file key, abort file
// - Authentication reply with auth response code
// - Responses use response, unsolicited or auth response code
// - All-stations and class event indications
// - Need time, local and trouble indications
// - Restart bit held until master writes
// - Unknown code, object, parameter indications
// - Event overflow with lost event indication
// - Bad config bit; unsupported, reserved zero
// - Last transmitted indications saved for readback
module dfh_outstation #(
  parameter NPTS = 8,             // Counter and output points
  parameter CW   = 32             // Counter width
) (
  input  wire              clk,
  input  wire              arst_n,
  // Decoded request from the link layer (same clock)
  input  wire              req_valid,
  input  wire [7:0]        req_fc,
  input  wire              req_con,         // Confirmation requested
  input  wire              req_all_st,      // All-stations address
  input  wire              req_obj_unk,     // Object not known
  input  wire              req_param_err,   // Qualifier or range unusable
  input  wire [NPTS-1:0]   req_pts,         // Addressed points
  // Device state levels (external, synchronised here)
  input  wire [2:0]        evt_pending,
  input  wire              evt_overflow,
  input  wire              ctl_not_exec,
  input  wire              ctl_fault,
  input  wire              cfg_bad,
  input  wire              drv_configured,  // Driver configured level; its rise sets restart and need-time
  // Counter inputs (same clock), one increment strobe per point
  input  wire [NPTS-1:0]   cnt_inc,
  // Response header out
  output reg               rsp_valid,
  output reg  [7:0]        rsp_fc,
  output reg  [7:0]        rsp_iin1,
  output reg  [7:0]        rsp_iin2,
  output reg               rsp_data,        // Object data follows
  output reg               cfm_valid,       // Confirm fragment
  // Action strobes and levels
  output reg  [NPTS-1:0]   out_apply,       // Control applied to points
  output reg               store_obj,
  output reg               cold_rst,
  output reg               warm_rst,
  output reg  [2:0]        app_cmd,         // Init, start, stop
  output reg               unsol_en,
  output reg               delay_meas,
  output reg               rec_time,
  output reg  [5:0]        file_cmd,        // Open,close,del,info,key,abort
  output reg               act_cfg,
  output reg               auth_msg,
  output reg  [CW-1:0]     frozen_sel,      // Frozen value of point 0
  // Avalon-MM slave
  input  wire [3:0]        avs_address,     // Word index
  input  wire              avs_read,
  input  wire              avs_write,
  input  wire [31:0]       avs_writedata,
  output reg  [31:0]       avs_readdata,
  output reg               avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // True for codes that expect no response
  function no_rsp;
    input [7:0] fc;
    begin
      no_rsp = (fc == `DFH_FC_DIR_OP_NR) || (fc == `DFH_FC_FRZ_NR) ||
               (fc == `DFH_FC_FRZ_CLR_NR) || (fc == `DFH_FC_AUTH_NR) ||
               (fc == `DFH_FC_CONFIRM);
    end
  endfunction

  // True for any code this block understands
  function known_fc;
    input [7:0] fc;
    begin
      known_fc = (fc <= `DFH_FC_FRZ_CLR_NR) ||
                 (fc >= `DFH_FC_COLD && fc <= `DFH_FC_WARM) ||
                 (fc >= `DFH_FC_INIT_APP && fc <= `DFH_FC_STOP_APP) ||
                 (fc == `DFH_FC_UNSOL_EN) || (fc == `DFH_FC_UNSOL_DIS) ||
                 (fc >= `DFH_FC_DELAY && fc <= `DFH_FC_AUTH_NR);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers for external status levels

  // Bits: 7 configured, 6 bad config, 5 fault, 4 not executing, 3 overflow, 2:0 events
  reg [7:0] sy1_q;                // First stage, read only by second
  reg [7:0] sy2_q;                // Second stage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sy1_q <= 8'h00;
      sy2_q <= 8'h00;
    end else begin
      sy1_q <= {drv_configured, cfg_bad, ctl_fault, ctl_not_exec,
                evt_overflow, evt_pending};
      sy2_q <= sy1_q;
    end
  end
  reg drv_d1_q;                   // Edge detect on configured level
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) drv_d1_q <= 1'b0;
    else drv_d1_q <= sy2_q[7];
  end
  wire drv_rise = sy2_q[7] & ~drv_d1_q;

  ////////////////////////////////////////////////////////////////////////
  // Register state

  reg [15:0]     sticky_q;        // Latched indication bits
  reg [15:0]     last_iin_q;      // Last transmitted word
  reg [NPTS-1:0] sel_q;           // Points armed by select
  reg            sel_vld_q;
  reg [31:0]     req_cnt_q;       // Requests taken
  reg [CW-1:0]   cnt_q [0:NPTS-1];
  reg [CW-1:0]   frz_q [0:NPTS-1];
  reg            unsol_pend_q;    // Software asked for unsolicited send

  wire bus_wr = avs_write & ~avs_waitrequest;
  wire ctl_wr = bus_wr && (avs_address == `DFH_A_CTRL);
  wire [15:0] iin_now;

  wire is_fc   = req_valid;
  wire fc_frz  = is_fc && (req_fc == `DFH_FC_FRZ || req_fc == `DFH_FC_FRZ_NR);
  wire fc_frzc = is_fc && (req_fc == `DFH_FC_FRZ_CLR || req_fc == `DFH_FC_FRZ_CLR_NR);

  // Live indication word; IIN2.4, .6, .7 stay zero
  assign iin_now = {2'b00, sy2_q[6], 1'b0, sy2_q[3],
                    sticky_q[`DFH_IIN_PARAM:`DFH_IIN_NO_FC],
                    sticky_q[`DFH_IIN_RESTART], sy2_q[5], sy2_q[4],
                    sticky_q[`DFH_IIN_NEED_TIME],
                    sy2_q[2:0], sticky_q[`DFH_IIN_ALL_ST]};

  ////////////////////////////////////////////////////////////////////////
  // Sticky indication bits: sets win over clears

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sticky_q <= `DFH_RST_W16;
    end else begin
      // Software clear of error bits
      if (ctl_wr && avs_writedata[`DFH_CTRL_CLR_ERR]) begin
        sticky_q[`DFH_IIN_ALL_ST] <= 1'b0;
        sticky_q[`DFH_IIN_PARAM:`DFH_IIN_NO_FC] <= 3'b000;
      end
      // Time set by software clears need-time
      if (ctl_wr && avs_writedata[`DFH_CTRL_SET_TIME])
        sticky_q[`DFH_IIN_NEED_TIME] <= 1'b0;
      // Master write clears restart
      if (is_fc && req_fc == `DFH_FC_WRITE)
        sticky_q[`DFH_IIN_RESTART] <= 1'b0;
      // Sets follow, so they win
      if (drv_rise || (ctl_wr && avs_writedata[`DFH_CTRL_RESTART]))
        sticky_q[`DFH_IIN_RESTART] <= 1'b1;
      if (drv_rise)
        sticky_q[`DFH_IIN_NEED_TIME] <= 1'b1;
      if (is_fc && req_all_st)
        sticky_q[`DFH_IIN_ALL_ST] <= 1'b1;
      if (is_fc && !known_fc(req_fc))
        sticky_q[`DFH_IIN_NO_FC] <= 1'b1;
      if (is_fc && req_obj_unk)
        sticky_q[`DFH_IIN_OBJ_UNK] <= 1'b1;
      if (is_fc && req_param_err)
        sticky_q[`DFH_IIN_PARAM] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counters with freeze and freeze-clear per point

  genvar g;
  generate
    for (g = 0; g < NPTS; g = g + 1) begin : g_cnt
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_q[g] <= {CW{1'b0}};
          frz_q[g] <= {CW{1'b0}};
        end else if ((fc_frz || fc_frzc) && req_pts[g]) begin
          frz_q[g] <= cnt_q[g];
          // Clear drops an increment landing this cycle
          cnt_q[g] <= fc_frzc ? {CW{1'b0}} : cnt_q[g] + {{(CW-1){1'b0}}, cnt_inc[g]};
        end else if (cnt_inc[g]) begin
          cnt_q[g] <= cnt_q[g] + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Dispatcher: one request a cycle, responses one cycle later

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_fc <= `DFH_RST_B8;
      rsp_iin1 <= `DFH_RST_B8;
      rsp_iin2 <= `DFH_RST_B8;
      rsp_data <= 1'b0;
      cfm_valid <= 1'b0;
      out_apply <= {NPTS{1'b0}};
      store_obj <= 1'b0;
      cold_rst <= 1'b0;
      warm_rst <= 1'b0;
      app_cmd <= 3'b000;
      unsol_en <= 1'b0;
      delay_meas <= 1'b0;
      rec_time <= 1'b0;
      file_cmd <= 6'h00;
      act_cfg <= 1'b0;
      auth_msg <= 1'b0;
      sel_q <= {NPTS{1'b0}};
      sel_vld_q <= 1'b0;
      last_iin_q <= `DFH_RST_W16;
      req_cnt_q <= `DFH_RST_W32;
      unsol_pend_q <= 1'b0;
      frozen_sel <= {CW{1'b0}};
    end else begin
      // Strobes default low
      rsp_valid <= 1'b0;
      rsp_data <= 1'b0;
      cfm_valid <= 1'b0;
      out_apply <= {NPTS{1'b0}};
      store_obj <= 1'b0;
      cold_rst <= 1'b0;
      warm_rst <= 1'b0;
      app_cmd <= 3'b000;
      delay_meas <= 1'b0;
      rec_time <= 1'b0;
      file_cmd <= 6'h00;
      act_cfg <= 1'b0;
      auth_msg <= 1'b0;
      frozen_sel <= frz_q[0];
      if (is_fc) begin
        req_cnt_q <= req_cnt_q + 32'h00000001;
        cfm_valid <= req_con;
        if (!no_rsp(req_fc)) begin
          rsp_valid <= 1'b1;
          rsp_fc <= (req_fc == `DFH_FC_AUTH) ? `DFH_FC_AUTH_RESP : `DFH_FC_RESP;
          rsp_iin1 <= iin_now[7:0];
          rsp_iin2 <= iin_now[15:8];
          last_iin_q <= iin_now;
        end
        // Any request other than select disarms a pending select
        if (req_fc != `DFH_FC_SELECT)
          sel_vld_q <= 1'b0;
        case (req_fc)
          `DFH_FC_READ:     rsp_data <= 1'b1;
          `DFH_FC_WRITE:    store_obj <= 1'b1;
          `DFH_FC_SELECT: begin
            sel_q <= req_pts;
            sel_vld_q <= 1'b1;
          end
          `DFH_FC_OPERATE: begin
            if (sel_vld_q && sel_q == req_pts)
              out_apply <= req_pts;
          end
          `DFH_FC_DIR_OP, `DFH_FC_DIR_OP_NR: out_apply <= req_pts;
          `DFH_FC_COLD:      cold_rst <= 1'b1;
          `DFH_FC_WARM:      warm_rst <= 1'b1;
          `DFH_FC_INIT_APP:  app_cmd <= 3'b001;
          `DFH_FC_START_APP: app_cmd <= 3'b010;
          `DFH_FC_STOP_APP:  app_cmd <= 3'b100;
          `DFH_FC_UNSOL_EN:  unsol_en <= 1'b1;
          `DFH_FC_UNSOL_DIS: unsol_en <= 1'b0;
          `DFH_FC_DELAY:     delay_meas <= 1'b1;
          `DFH_FC_REC_TIME:  rec_time <= 1'b1;
          `DFH_FC_OPEN:      file_cmd <= 6'h01;
          `DFH_FC_CLOSE:     file_cmd <= 6'h02;
          `DFH_FC_DELETE:    file_cmd <= 6'h04;
          `DFH_FC_FINFO:     file_cmd <= 6'h08;
          `DFH_FC_FAUTH:     file_cmd <= 6'h10;
          `DFH_FC_ABORT:     file_cmd <= 6'h20;
          `DFH_FC_ACT_CFG:   act_cfg <= 1'b1;
          `DFH_FC_AUTH, `DFH_FC_AUTH_NR: auth_msg <= 1'b1;
          default: ;
        endcase
      end else if (unsol_pend_q && unsol_en) begin
        // Unsolicited send only in idle cycles; held until enabled
        unsol_pend_q <= 1'b0;
        rsp_valid <= 1'b1;
        rsp_data <= 1'b1;
        rsp_fc <= `DFH_FC_UNSOL_RESP;
        rsp_iin1 <= iin_now[7:0];
        rsp_iin2 <= iin_now[15:8];
        last_iin_q <= iin_now;
      end
      // Software request last, so a new one landing as the old is sent wins
      if (ctl_wr && avs_writedata[`DFH_CTRL_UNSOL_REQ])
        unsol_pend_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle then a one-cycle answer

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `DFH_RST_W32;
    end else begin
      // Drop waitrequest for one cycle per access
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if ((avs_read | avs_write) && avs_waitrequest) begin
        if (avs_address == `DFH_A_CTRL)
          avs_readdata <= {31'h00000000, unsol_en};
        else if (avs_address == `DFH_A_STATUS)
          avs_readdata <= {30'h00000000, unsol_pend_q, sel_vld_q};
        else if (avs_address == `DFH_A_IIN)
          avs_readdata <= {16'h0000, iin_now};
        else if (avs_address == `DFH_A_LAST_IIN)
          avs_readdata <= {16'h0000, last_iin_q};
        else if (avs_address == `DFH_A_SEL_PTS)
          avs_readdata <= {{(32-NPTS){1'b0}}, sel_q};
        else if (avs_address == `DFH_A_COUNT)
          avs_readdata <= req_cnt_q;
        else
          avs_readdata <= `DFH_RST_W32;  // Unmapped reads as zero
      end
    end
  end

  // Reads have no side effect, so no read strobe is decoded
endmodule // dfh_outstation

// ==== tb/dfh_chk.sv ====
// Concurrent checks on the outstation request, response and control ports
`timescale 1ns/1ps
`include "dfh_regs.vh"
module dfh_chk #(
  parameter NPTS = 8,
  parameter CW   = 32
) (
  input wire            clk,
  input wire            arst_n,
  input wire            req_valid,
  input wire [7:0]      req_fc,
  input wire            req_con,
  input wire [NPTS-1:0] req_pts,
  input wire            rsp_valid,
  input wire [7:0]      rsp_fc,
  input wire [7:0]      rsp_iin2,
  input wire            rsp_data,
  input wire            cfm_valid,
  input wire [NPTS-1:0] out_apply
);
  reg            armed_q; // Last request was a select
  reg [NPTS-1:0] pts_q;   // Points of that last request
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Select tracking: any other request disarms, so a gap does not matter
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= 1'b0;
      pts_q   <= {NPTS{1'b0}};
    end else if (req_valid) begin
      armed_q <= (req_fc == `DFH_FC_SELECT);
      pts_q   <= req_pts;
    end
  end
  sequence s_op_req;
    req_valid && req_fc == `DFH_FC_OPERATE;
  endsequence
  sequence s_armed_op;
    s_op_req ##0 (armed_q && req_pts == pts_q);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_read_resp: assert property (req_valid && req_fc == `DFH_FC_READ |=>
    rsp_valid && rsp_data && rsp_fc == `DFH_FC_RESP) else $error("read answer wrong");
  a_no_resp: assert property (req_valid && (req_fc == `DFH_FC_DIR_OP_NR ||
    req_fc == `DFH_FC_FRZ_NR || req_fc == `DFH_FC_FRZ_CLR_NR || req_fc == `DFH_FC_AUTH_NR)
    |=> !rsp_valid) else $error("response to a silent code");
  a_auth_reply: assert property (req_valid && req_fc == `DFH_FC_AUTH |=>
    rsp_valid && rsp_fc == `DFH_FC_AUTH_RESP) else $error("auth reply code wrong");
  a_confirm_echo: assert property (req_valid && req_con |=> cfm_valid)
    else $error("confirm missing");
  a_iin_zero: assert property (rsp_iin2[7:6] == 2'b00 && !rsp_iin2[4])
    else $error("unused indication set");
  a_sbo_accept: assert property (s_armed_op |=> out_apply == $past(req_pts))
    else $error("operate after select not applied");
  a_sbo_reject: assert property (s_op_req ##0 !(armed_q && req_pts == pts_q)
    |=> out_apply == {NPTS{1'b0}} && rsp_valid) else $error("stray operate applied");
  a_direct_op: assert property (req_valid && req_fc == `DFH_FC_DIR_OP |=>
    out_apply == $past(req_pts) && rsp_valid) else $error("direct operate wrong");
  a_unknown_fc: assert property (req_valid && req_fc == 8'h0b |=>
    rsp_valid && rsp_fc == `DFH_FC_RESP) else $error("unknown code not answered");
endmodule // dfh_chk
bind dfh_outstation dfh_chk #(.NPTS(NPTS), .CW(CW)) u_chk (.clk(clk), .arst_n(arst_n),
  .req_valid(req_valid), .req_fc(req_fc), .req_con(req_con), .req_pts(req_pts),
  .rsp_valid(rsp_valid), .rsp_fc(rsp_fc), .rsp_iin2(rsp_iin2), .rsp_data(rsp_data),
  .cfm_valid(cfm_valid), .out_apply(out_apply));

// ==== tb/dfh_master_model.sv ====
// Master station model: turns bench commands into one-cycle decoded requests
`timescale 1ns/1ps
module dfh_master_model (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       go,        // Issue one request
  input  wire [7:0] fc,
  input  wire [7:0] pts,
  input  wire [3:0] flags,     // {param, unknown obj, all stations, confirm}
  output reg        req_valid,
  output reg  [7:0] req_fc,
  output reg  [7:0] req_pts,
  output reg        req_con,
  output reg        req_all_st,
  output reg        req_obj_unk,
  output reg        req_param_err
);
  // Fields toggle between requests so nothing leans on stale values
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_valid <= 1'b0;
      req_fc    <= 8'h00;
      req_pts   <= 8'h00;
      {req_param_err, req_obj_unk, req_all_st, req_con} <= 4'h0;
    end else begin
      req_valid <= go;
      req_fc    <= go ? fc : ~req_fc;
      req_pts   <= go ? pts : ~req_pts;
      {req_param_err, req_obj_unk, req_all_st, req_con} <= go ? flags :
        ~{req_param_err, req_obj_unk, req_all_st, req_con};
    end
  end
endmodule // dfh_master_model

// ==== tb/test_dfh_outstation.sv ====
// Self-checking bench for the outstation interpreter
`timescale 1ns/1ps
`include "dfh_regs.vh"
module test_dfh_outstation;
  localparam [223:0] CODES = {8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
    8'h0a, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h14, 8'h15, 8'h17, 8'h18, 8'h19, 8'h1a,
    8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h00};
  reg         clk = 0, arst_n = 0, go = 0, avs_read = 0, avs_write = 0;
  reg  [7:0]  m_fc = 0, m_pts = 0, cnt_inc = 0;
  reg  [3:0]  m_fl = 0, avs_address = 0;
  reg  [2:0]  evt_pending = 0;
  reg         evt_overflow = 0, ctl_not_exec = 0, ctl_fault = 0, cfg_bad = 0;
  reg         drv_configured = 0;
  reg  [31:0] avs_writedata = 0, q;
  integer     mismatches = 0, checks_done = 0, i, n;
  wire        req_valid, req_con, req_all_st, req_obj_unk, req_param_err;
  wire [7:0]  req_fc, req_pts, rsp_fc, rsp_iin1, rsp_iin2, out_apply;
  wire        rsp_valid, rsp_data, cfm_valid, store_obj, cold_rst, warm_rst, unsol_en;
  wire        delay_meas, rec_time, act_cfg, auth_msg, avs_waitrequest;
  wire [2:0]  app_cmd;
  wire [5:0]  file_cmd;
  wire [31:0] frozen_sel, avs_readdata;
  always #2.5 clk = ~clk;
  dfh_master_model u_mst (.clk(clk), .arst_n(arst_n), .go(go), .fc(m_fc), .pts(m_pts),
    .flags(m_fl), .req_valid(req_valid), .req_fc(req_fc), .req_pts(req_pts),
    .req_con(req_con), .req_all_st(req_all_st), .req_obj_unk(req_obj_unk),
    .req_param_err(req_param_err));
  dfh_outstation #(.NPTS(8), .CW(32)) u_dut (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_fc(req_fc), .req_con(req_con), .req_all_st(req_all_st),
    .req_obj_unk(req_obj_unk), .req_param_err(req_param_err), .req_pts(req_pts),
    .evt_pending(evt_pending), .evt_overflow(evt_overflow), .ctl_not_exec(ctl_not_exec),
    .ctl_fault(ctl_fault), .cfg_bad(cfg_bad), .drv_configured(drv_configured),
    .cnt_inc(cnt_inc), .rsp_valid(rsp_valid), .rsp_fc(rsp_fc), .rsp_iin1(rsp_iin1),
    .rsp_iin2(rsp_iin2), .rsp_data(rsp_data), .cfm_valid(cfm_valid),
    .out_apply(out_apply), .store_obj(store_obj), .cold_rst(cold_rst),
    .warm_rst(warm_rst), .app_cmd(app_cmd), .unsol_en(unsol_en),
    .delay_meas(delay_meas), .rec_time(rec_time), .file_cmd(file_cmd),
    .act_cfg(act_cfg), .auth_msg(auth_msg), .frozen_sel(frozen_sel),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One request; returns while the answer pulse stands
  task send(input [7:0] fc, input [7:0] pts, input [3:0] fl);
    begin
      @(posedge clk);
      go <= 1; m_fc <= fc; m_pts <= pts; m_fl <= fl;
      @(posedge clk);
      go <= 0;
      @(posedge clk);
      #1;
    end
  endtask
  // Avalon access held until waitrequest is seen low
  task av(input wr, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      avs_read <= !wr; avs_write <= wr; avs_address <= a; avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 0; avs_write <= 0;
    end
  endtask
  task inc(input integer k);
    repeat (k) begin
      @(posedge clk) cnt_inc <= 8'h01;
      @(posedge clk) cnt_inc <= 8'h00;
    end
  endtask
  // Action strobe expected per code: {auth,act,file[5:0],rec,delay,app[2:0],warm,cold,store}
  function [15:0] exp_act(input [7:0] fc);
    case (fc)
      8'h02: exp_act = 16'h0001;
      8'h0d: exp_act = 16'h0002;
      8'h0e: exp_act = 16'h0004;
      8'h10: exp_act = 16'h0008;
      8'h11: exp_act = 16'h0010;
      8'h12: exp_act = 16'h0020;
      8'h17: exp_act = 16'h0040;
      8'h18: exp_act = 16'h0080;
      8'h1f: exp_act = 16'h4000;
      8'h20, 8'h21: exp_act = 16'h8000;
      default: exp_act = (fc >= 8'h19 && fc <= 8'h1e) ? 16'h0100 << (fc - 8'h19) : 16'h0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Indication word: sources, response octets, readback and clears
  task t_iin;
    begin
      evt_pending <= 3'b010; evt_overflow <= 1; ctl_not_exec <= 1;
      ctl_fault <= 1; cfg_bad <= 1; drv_configured <= 1;
      send(`DFH_FC_READ, 0, 4'b0010);
      send(8'h0b, 0, 0);
      send(`DFH_FC_READ, 0, 4'b0100);
      send(`DFH_FC_READ, 0, 4'b1000);
      send(`DFH_FC_READ, 0, 0);
      chk({rsp_iin2, rsp_iin1}, 32'h2ff5);
      av(0, `DFH_A_IIN, 0); chk(q, 32'h2ff5);
      av(0, `DFH_A_LAST_IIN, 0); chk(q, 32'h2ff5);
      send(`DFH_FC_WRITE, 0, 0); chk(store_obj, 1);
      av(1, `DFH_A_CTRL, 32'h3);
      av(0, `DFH_A_IIN, 0); chk(q, 32'h2864);
      @(posedge clk);
      evt_pending <= 0; evt_overflow <= 0; ctl_not_exec <= 0; ctl_fault <= 0; cfg_bad <= 0;
      repeat (4) @(posedge clk);
      av(0, `DFH_A_IIN, 0); chk(q, 32'h0);
      av(1, `DFH_A_CTRL, 32'h8);
      av(0, `DFH_A_IIN, 0); chk(q, 32'h80);
      av(0, 4'hf, 0); chk(q, 32'h0);
      $display("t_iin done");
    end
  endtask
  // Every code but operate: answer presence, answer code, action strobe
  task t_codes;
    reg [7:0] fc;
    reg       nr;
    for (i = 0; i < 28; i = i + 1) begin
      fc = CODES[8*(27-i) +: 8];
      nr = fc == 8'h00 || fc == 8'h06 || fc == 8'h08 || fc == 8'h0a || fc == 8'h21;
      send(fc, 0, {3'b000, fc == 8'h01});
      chk(rsp_valid, !nr);
      if (!nr) chk(rsp_fc, fc == 8'h20 ? 8'h83 : 8'h81);
      chk({auth_msg, act_cfg, file_cmd, rec_time, delay_meas, app_cmd, warm_rst, cold_rst,
        store_obj}, exp_act(fc));
      if (fc == 8'h14 || fc == 8'h15) chk(unsol_en, fc == 8'h14);
      if (fc == 8'h01) chk({rsp_data, cfm_valid}, 2'b11);
    end
    $display("t_codes done");
  endtask
  // Select before operate, refusals and direct operate
  task t_sbo;
    begin
      send(3, 8'h05, 0);
      av(0, `DFH_A_STATUS, 0); chk(q, 32'h1);
      av(0, `DFH_A_SEL_PTS, 0); chk(q, 32'h5);
      send(4, 8'h05, 0); chk(out_apply, 8'h05);
      send(4, 8'h05, 0); chk({rsp_valid, out_apply}, 9'h100);
      send(3, 8'h05, 0); send(4, 8'h06, 0); chk(out_apply, 8'h00);
      send(3, 8'h05, 0); send(1, 0, 0); send(4, 8'h05, 0); chk(out_apply, 8'h00);
      send(5, 8'h09, 0); chk({rsp_valid, out_apply}, 9'h109);
      send(6, 8'h0a, 0); chk({rsp_valid, out_apply}, 9'h00a);
      $display("t_sbo done");
    end
  endtask
  // Freeze and freeze-clear on point 0
  task t_frz;
    begin
      inc(3); send(7, 1, 0); @(posedge clk); #1 chk(frozen_sel, 3);
      inc(2); chk(frozen_sel, 3);
      send(9, 1, 0); @(posedge clk); #1 chk(frozen_sel, 5);
      inc(1); send(8, 1, 0); @(posedge clk); #1 chk(frozen_sel, 1);
      inc(1); send(7, 2, 0); @(posedge clk); #1 chk(frozen_sel, 1);
      send(8'h0a, 1, 0); send(7, 1, 0); @(posedge clk); #1 chk(frozen_sel, 0);
      $display("t_frz done");
    end
  endtask
  // Unsolicited response after run-time enable
  task t_unsol;
    begin
      send(8'h14, 0, 0);
      av(1, `DFH_A_CTRL, 32'h4);
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20) begin
        @(posedge clk); #1 n = n + 1;
      end
      chk({rsp_valid, rsp_data, rsp_fc}, 10'h382);
      av(0, `DFH_A_CTRL, 0); chk(q, 32'h1);
      send(8'h15, 0, 0);
      $display("t_unsol done");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    begin
      $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1;
    t_iin; t_codes; t_sbo; t_frz; t_unsol;
    close_out;
  end
  // Run needs a few hundred cycles; this is ample
  initial begin
    #100000;
    mismatches = mismatches + 1;
    close_out;
  end
endmodule // test_dfh_outstation
